// *** design/drr_pkg.sv ***
// Constants and types for the row repair tracker
package drr_pkg;
	// Spare rows: one per bank in each organisation
	localparam int BANKS_X8  = 16;
	localparam int BANKS_X16 = 8;
	localparam int ROW_W     = 18;
	localparam int MR_DATA_W = 18;

	// Mode register select and field positions
	localparam logic [2:0] MR_FOUR_SEL  = 3'h4;
	localparam int         SOFT_EN_BIT  = 5;
	localparam int         HARD_EN_BIT  = 13;
	localparam logic       SOFT_EN_RST  = 1'h0;
	localparam logic       HARD_EN_RST  = 1'h0;

	// Readout pages and locations
	localparam logic [1:0] SUPPORT_PAGE = 2'h2;
	localparam logic [1:0] SUPPORT_LOC  = 2'h0;
	localparam int         HARD_SUP_BIT = 7;
	localparam int         SOFT_SUP_BIT = 6;
	localparam logic [1:0] ACT_PAGE     = 2'h3;
	localparam logic [1:0] ACT_LOC      = 2'h3;
	localparam logic [7:0] READOUT_RST  = 8'h00;

	// Activate limit field codes, bits 7:4 read as zero
	localparam logic [3:0] ACT_UNTESTED  = 4'h0;
	localparam logic [3:0] ACT_700K      = 4'h1;
	localparam logic [3:0] ACT_600K      = 4'h2;
	localparam logic [3:0] ACT_500K      = 4'h3;
	localparam logic [3:0] ACT_400K      = 4'h4;
	localparam logic [3:0] ACT_300K      = 4'h5;
	localparam logic [3:0] ACT_200K      = 4'h7;
	localparam logic [3:0] ACT_UNLIMITED = 4'h8;

	// Per-bank spare row state, Gray along none, soft, hard
	typedef enum logic [1:0] {
		DRR_NONE = 2'h0,
		DRR_SOFT = 2'h1,
		DRR_HARD = 2'h3
	} drr_bank_state_t;

	// Repair kind of a request
	typedef enum logic [1:0] {
		DRR_KIND_NONE = 2'h0,
		DRR_KIND_SOFT = 2'h1,
		DRR_KIND_HARD = 2'h3
	} drr_kind_t;
endpackage

// *** design/drr_bank_store.sv ***
// Per-bank spare row storage with replacement rules
`timescale 1ns/1ps
module drr_bank_store #(
	parameter int BANKS = drr_pkg::BANKS_X8,
	parameter int BW    = $clog2(BANKS)
) (
	input  wire logic                         clk,
	input  wire logic                         rst_b,
	input  wire logic                         por_b,
	input  wire logic                         wr_en,
	input  wire drr_pkg::drr_kind_t           wr_kind,
	input  wire logic [BW-1:0]                wr_bank,
	input  wire logic [drr_pkg::ROW_W-1:0]    wr_row,
	output logic [2*BANKS-1:0]                state_vec,
	output logic [BANKS*drr_pkg::ROW_W-1:0]   row_vec
);
	drr_pkg::drr_bank_state_t         st_q  [BANKS];
	drr_pkg::drr_bank_state_t         st_d  [BANKS];
	logic [drr_pkg::ROW_W-1:0]        row_q [BANKS];
	logic [drr_pkg::ROW_W-1:0]        row_d [BANKS];

	genvar g;
	generate
		for (g = 0; g < BANKS; g++) begin : g_bank
			// Only the addressed bank moves; others keep soft entries too
			always_comb begin
				st_d[g]  = st_q[g];
				row_d[g] = row_q[g];
				if (wr_en && wr_bank == BW'(g) && st_q[g] != drr_pkg::DRR_HARD) begin
					row_d[g] = wr_row;
					if (wr_kind == drr_pkg::DRR_KIND_HARD) begin
						st_d[g] = drr_pkg::DRR_HARD;
					end else begin
						st_d[g] = drr_pkg::DRR_SOFT;
					end
				end
			end

			// Power loss drops all; device reset drops only soft entries
			always_ff @(posedge clk) begin
				if (!por_b) begin
					st_q[g]  <= drr_pkg::DRR_NONE;
					row_q[g] <= '0;
				end else if (!rst_b && st_q[g] != drr_pkg::DRR_HARD) begin
					st_q[g]  <= drr_pkg::DRR_NONE;
					row_q[g] <= '0;
				end else begin
					st_q[g]  <= st_d[g];
					row_q[g] <= row_d[g];
				end
			end

			assign state_vec[2*g +: 2] = st_q[g];
			assign row_vec[g*drr_pkg::ROW_W +: drr_pkg::ROW_W] = row_q[g];
		end
	endgenerate
endmodule

// *** design/drr_tracker.sv ***
// Row repair tracker: mode bits, repair requests, lookup and readout pages
//
// Contract
// - Soft repair is reversible and reassignable
// - Hard repair is permanent, never reversed; power loss (por_b low) clears it here
// - Hard support at page 2 location 0 bit 7
// - Soft support at page 2 location 0 bit 6
// - One spare row per bank, 16 or 8
// - Hard mode entry allowed with soft entries
// - Repair leaves other banks' soft entries intact
// - Later soft repair replaces earlier soft
// - Hard repair takes over a soft spare row
// - Hard entry never cleared or overwritten; the store clears it when por_b is low
// - Background refresh, activations unrestricted
// - Page 3 location 3 bits 3:0 read 1000
// - Activate limit field encoding, upper bits zero
// - Mode register four bit 5 enables soft
// - Mode register four bit 13 enables hard
`timescale 1ns/1ps
module drr_tracker #(
	parameter int         BANKS      = drr_pkg::BANKS_X8,
	parameter logic       HARD_SUP   = 1'h1,
	parameter logic       SOFT_SUP   = 1'h1,
	parameter logic [3:0] ACT_LIMIT  = drr_pkg::ACT_UNLIMITED,
	parameter int         BW         = $clog2(BANKS)
) (
	input  wire logic                          clk,
	input  wire logic                          rst_b,
	input  wire logic                          por_b,
	input  wire logic                          mr_wr,
	input  wire logic [2:0]                    mr_sel,
	input  wire logic [drr_pkg::MR_DATA_W-1:0] mr_data,
	input  wire logic                          repair_req,
	input  wire logic [BW-1:0]                 repair_bank,
	input  wire logic [drr_pkg::ROW_W-1:0]     repair_row,
	input  wire logic                          lookup_req,
	input  wire logic [BW-1:0]                 lookup_bank,
	input  wire logic [drr_pkg::ROW_W-1:0]     lookup_row,
	input  wire logic                          readout_req,
	input  wire logic [1:0]                    readout_page,
	input  wire logic [1:0]                    readout_loc,
	output logic                               soft_mode,
	output logic                               hard_mode,
	output logic                               repair_done,
	output logic                               repair_refused,
	output logic                               lookup_valid,
	output logic                               lookup_hit,
	output logic                               readout_valid,
	output logic [7:0]                         readout_data,
	output logic [2*BANKS-1:0]                 bank_state
);
	// Readout decode, used by the read path
	function automatic logic [7:0] drr_readout(input logic [1:0] page, input logic [1:0] loc);
		logic [7:0] v;
		v = drr_pkg::READOUT_RST;
		if (page == drr_pkg::SUPPORT_PAGE && loc == drr_pkg::SUPPORT_LOC) begin
			v[drr_pkg::HARD_SUP_BIT] = HARD_SUP;
			v[drr_pkg::SOFT_SUP_BIT] = SOFT_SUP;
		end else if (page == drr_pkg::ACT_PAGE && loc == drr_pkg::ACT_LOC) begin
			v[3:0] = ACT_LIMIT;
		end
		return v;
	endfunction

	// Bank index compare, used by repair and lookup paths
	function automatic logic drr_in_range(input logic [BW-1:0] b);
		return ({1'h0, b} < (BW+1)'(BANKS));
	endfunction

	// Mode register state
	logic soft_en_q;
	logic soft_en_d;
	logic hard_en_q;
	logic hard_en_d;

	// Request stage
	logic                       req_q;
	logic                       req_d;
	drr_pkg::drr_kind_t         kind_q;
	drr_pkg::drr_kind_t         kind_d;
	logic [BW-1:0]              bank_q;
	logic [BW-1:0]              bank_d;
	logic [drr_pkg::ROW_W-1:0]  row_q;
	logic [drr_pkg::ROW_W-1:0]  row_d;

	// Outputs
	logic                       done_q;
	logic                       done_d;
	logic                       refused_q;
	logic                       refused_d;
	logic                       lk_valid_q;
	logic                       lk_valid_d;
	logic                       lk_hit_q;
	logic                       lk_hit_d;
	logic                       rd_valid_q;
	logic                       rd_valid_d;
	logic [7:0]                 rd_data_q;
	logic [7:0]                 rd_data_d;
	logic [2*BANKS-1:0]         bank_state_q;

	// Store wiring
	logic                       st_wr;
	logic [2*BANKS-1:0]         st_vec;
	logic [BANKS*drr_pkg::ROW_W-1:0] st_rows;
	drr_pkg::drr_bank_state_t   tgt_state;
	drr_pkg::drr_bank_state_t   lk_state;

	// Mode bits follow each write to mode register four
	always_comb begin
		soft_en_d = soft_en_q;
		hard_en_d = hard_en_q;
		if (mr_wr && mr_sel == drr_pkg::MR_FOUR_SEL) begin
			soft_en_d = mr_data[drr_pkg::SOFT_EN_BIT];
			hard_en_d = mr_data[drr_pkg::HARD_EN_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			soft_en_q <= drr_pkg::SOFT_EN_RST;
			hard_en_q <= drr_pkg::HARD_EN_RST;
		end else begin
			soft_en_q <= soft_en_d;
			hard_en_q <= hard_en_d;
		end
	end

	// Capture a request with the kind set by the current mode bits.
	// Both modes on is illegal; the kind then becomes none and is refused.
	always_comb begin
		req_d  = repair_req;
		bank_d = repair_bank;
		row_d  = repair_row;
		if (soft_en_q && !hard_en_q) begin
			kind_d = drr_pkg::DRR_KIND_SOFT;
		end else if (hard_en_q && !soft_en_q) begin
			kind_d = drr_pkg::DRR_KIND_HARD;
		end else begin
			kind_d = drr_pkg::DRR_KIND_NONE;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			req_q  <= 1'h0;
			kind_q <= drr_pkg::DRR_KIND_NONE;
			bank_q <= '0;
			row_q  <= '0;
		end else begin
			req_q  <= req_d;
			kind_q <= kind_d;
			bank_q <= bank_d;
			row_q  <= row_d;
		end
	end

	// State of the addressed bank before the write lands
	always_comb begin
		tgt_state = drr_pkg::drr_bank_state_t'(st_vec[2*bank_q +: 2]);
		lk_state  = drr_pkg::drr_bank_state_t'(st_vec[2*lookup_bank +: 2]);
	end

	// A hard bank, a bad index or an illegal mode refuses the request
	assign st_wr = req_q && kind_q != drr_pkg::DRR_KIND_NONE && drr_in_range(bank_q) &&
	               tgt_state != drr_pkg::DRR_HARD;

	drr_bank_store #(
		.BANKS (BANKS),
		.BW    (BW)
	) u_store (
		.clk       (clk),
		.rst_b     (rst_b),
		.por_b     (por_b),
		.wr_en     (st_wr),
		.wr_kind   (kind_q),
		.wr_bank   (bank_q),
		.wr_row    (row_q),
		.state_vec (st_vec),
		.row_vec   (st_rows)
	);

	// Result flags two cycles after the repair request; lookup and readout answered one cycle after their own request
	always_comb begin
		done_d     = st_wr;
		refused_d  = req_q && !st_wr;
		lk_valid_d = lookup_req;
		lk_hit_d   = 1'h0;
		if (lookup_req && drr_in_range(lookup_bank) && lk_state != drr_pkg::DRR_NONE) begin
			lk_hit_d = (st_rows[lookup_bank*drr_pkg::ROW_W +: drr_pkg::ROW_W] == lookup_row);
		end
		rd_valid_d = readout_req;
		rd_data_d  = readout_req ? drr_readout(readout_page, readout_loc) : drr_pkg::READOUT_RST;
	end

	// No activate counting: refresh of neighbours runs in the background,
	// so the reported limit is a strap rather than a tracked count.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			done_q       <= 1'h0;
			refused_q    <= 1'h0;
			lk_valid_q   <= 1'h0;
			lk_hit_q     <= 1'h0;
			rd_valid_q   <= 1'h0;
			rd_data_q    <= drr_pkg::READOUT_RST;
			bank_state_q <= st_vec; // Mirror the store so hard entries survive a reset while por_b stays high
		end else begin
			done_q       <= done_d;
			refused_q    <= refused_d;
			lk_valid_q   <= lk_valid_d;
			lk_hit_q     <= lk_hit_d;
			rd_valid_q   <= rd_valid_d;
			rd_data_q    <= rd_data_d;
			bank_state_q <= st_vec;
		end
	end

	assign soft_mode      = soft_en_q;
	assign hard_mode      = hard_en_q;
	assign repair_done    = done_q;
	assign repair_refused = refused_q;
	assign lookup_valid   = lk_valid_q;
	assign lookup_hit     = lk_hit_q;
	assign readout_valid  = rd_valid_q;
	assign readout_data   = rd_data_q;
	assign bank_state     = bank_state_q;
endmodule

// *** verification/drr_monitor.sv ***
// Port assertions for the row repair tracker
`timescale 1ns/1ps
module drr_monitor #(
	parameter int         BANKS     = 16,
	parameter logic       HARD_SUP  = 1'h1,
	parameter logic       SOFT_SUP  = 1'h1,
	parameter logic [3:0] ACT_LIMIT = 4'h8,
	parameter int         BW        = 4
) (
	input wire logic                 clk,
	input wire logic                 rst_b,
	input wire logic                 por_b,
	input wire logic                 mr_wr,
	input wire logic [2:0]           mr_sel,
	input wire logic [17:0]          mr_data,
	input wire logic                 repair_req,
	input wire logic [BW-1:0]        repair_bank,
	input wire logic                 lookup_req,
	input wire logic                 readout_req,
	input wire logic [1:0]           readout_page,
	input wire logic [1:0]           readout_loc,
	input wire logic                 soft_mode,
	input wire logic                 hard_mode,
	input wire logic                 repair_done,
	input wire logic                 repair_refused,
	input wire logic                 lookup_valid,
	input wire logic                 readout_valid,
	input wire logic [7:0]           readout_data,
	input wire logic [2*BANKS-1:0]   bank_state
);
	logic [1:0]       por_q;
	logic [1:0]       por_d;
	logic [BANKS-1:0] hard_v;

	// Power-on history; bank_state lags, so wait two clean edges
	always_comb begin
		por_d = {por_q[0], por_b};
		for (int b = 0; b < BANKS; b++) begin
			hard_v[b] = bank_state[2*b+1];
		end
	end

	// History register
	always_ff @(posedge clk) begin
		por_q <= por_d;
	end

	default clocking dcb @(posedge clk); endclocking
	default disable iff (!rst_b);

	mode_load_a: assert property (mr_wr && mr_sel == 3'h4 |=>
		soft_mode == $past(mr_data[5]) && hard_mode == $past(mr_data[13])) else $error("mode bits not loaded");
	mode_hold_a: assert property (!(mr_wr && mr_sel == 3'h4) |=>
		$stable(soft_mode) && $stable(hard_mode)) else $error("mode bits changed unasked");
	one_answer_a: assert property (repair_req |-> ##2 (repair_done != repair_refused))
		else $error("repair answer missing");
	mode_refuse_a: assert property (repair_req && soft_mode == hard_mode |-> ##2 repair_refused)
		else $error("repair taken without one mode");
	hard_refuse_a: assert property (repair_req && bank_state[{repair_bank, 1'h0} +: 2] == 2'h3
		|-> ##2 repair_refused) else $error("hard bank accepted repair");
	done_cause_a: assert property (repair_done |-> $past(repair_req, 2)) else $error("stray done");
	lookup_lat_a: assert property (lookup_req |=> lookup_valid) else $error("lookup not answered");
	act_limit_a: assert property (readout_req && readout_page == 2'h3 && readout_loc == 2'h3
		|=> readout_valid && readout_data == {4'h0, ACT_LIMIT}) else $error("activate limit wrong");
	support_rd_a: assert property (readout_req && readout_page == 2'h2 && readout_loc == 2'h0
		|=> readout_data == {HARD_SUP, SOFT_SUP, 6'h00}) else $error("support bits wrong");
	idle_data_a: assert property (!readout_valid |-> readout_data == 8'h00) else $error("readout not idle");
	hard_keep_a: assert property (disable iff (!por_b || !(&por_q))
		($past(hard_v) & ~hard_v) == '0) else $error("hard entry lost");
endmodule

bind drr_tracker drr_monitor #(.BANKS(BANKS), .HARD_SUP(HARD_SUP), .SOFT_SUP(SOFT_SUP),
	.ACT_LIMIT(ACT_LIMIT), .BW(BW)) u_mon (.*);

// *** verification/drr_ctl_model.sv ***
// Memory controller model issuing mode, repair, lookup and readout requests
`timescale 1ns/1ps
module drr_ctl_model #(
	parameter int BW = 4
) (
	input  wire logic        clk,
	output logic             mr_wr,
	output logic [2:0]       mr_sel,
	output logic [17:0]      mr_data,
	output logic             repair_req,
	output logic [BW-1:0]    repair_bank,
	output logic [17:0]      repair_row,
	output logic             lookup_req,
	output logic [BW-1:0]    lookup_bank,
	output logic [17:0]      lookup_row,
	output logic             readout_req,
	output logic [1:0]       readout_page,
	output logic [1:0]       readout_loc,
	input  wire logic        repair_done,
	input  wire logic        repair_refused,
	input  wire logic        lookup_valid,
	input  wire logic        lookup_hit,
	input  wire logic        readout_valid,
	input  wire logic [7:0]  readout_data
);
	// Quiet bus at start
	initial begin
		{mr_wr, mr_sel, mr_data, repair_req, repair_bank, repair_row} = '0;
		{lookup_req, lookup_bank, lookup_row, readout_req, readout_page, readout_loc} = '0;
	end

	// Both enables only when a test asks for a refusal
	task automatic mode(input logic s, input logic h);
		@(negedge clk);
		mr_wr   <= 1'h1;
		mr_sel  <= 3'h4;
		mr_data <= {4'h0, h, 7'h00, s, 5'h00};
		@(negedge clk);
		mr_wr   <= 1'h0;
		mr_data <= ~mr_data;
	endtask

	// Released lines invert so stale values never look valid
	task automatic rep(input int b, input logic [17:0] r, output logic [1:0] res);
		@(negedge clk);
		repair_req  <= 1'h1;
		repair_bank <= b[BW-1:0];
		repair_row  <= r;
		@(negedge clk);
		repair_req  <= 1'h0;
		repair_bank <= ~repair_bank;
		repair_row  <= ~repair_row;
		// Answer stands one cycle only, so catch it right after it appears
		@(negedge clk);
		res = {repair_done, repair_refused};
		@(negedge clk);
	endtask

	// Lookup answers one cycle after the request edge
	task automatic lk(input int b, input logic [17:0] r, output logic [1:0] res);
		@(negedge clk);
		lookup_req  <= 1'h1;
		lookup_bank <= b[BW-1:0];
		lookup_row  <= r;
		@(negedge clk);
		res = {lookup_valid, lookup_hit};
		lookup_req <= 1'h0;
		lookup_row <= ~lookup_row;
	endtask

	// Readout page access; no activates issued, so no limit to keep
	task automatic rd(input logic [1:0] p, input logic [1:0] l, output logic [8:0] res);
		@(negedge clk);
		readout_req  <= 1'h1;
		readout_page <= p;
		readout_loc  <= l;
		@(negedge clk);
		res = {readout_valid, readout_data};
		readout_req <= 1'h0;
	endtask
endmodule

// *** verification/drr_tracker_tb.sv ***
// Self-checking testbench for the row repair tracker
`timescale 1ns/1ps
module drr_tracker_tb;
	localparam int BANKS = 16;
	localparam int BW    = 4;
	logic                clk = 1'h0;
	logic                rst_b;
	logic                por_b;
	logic                mr_wr, repair_req, lookup_req, readout_req;
	logic [2:0]          mr_sel;
	logic [17:0]         mr_data, repair_row, lookup_row;
	logic [BW-1:0]       repair_bank, lookup_bank;
	logic [1:0]          readout_page, readout_loc;
	logic                soft_mode, hard_mode, repair_done, repair_refused;
	logic                lookup_valid, lookup_hit, readout_valid;
	logic [7:0]          readout_data;
	logic [2*BANKS-1:0]  bank_state;
	int                  err_total = 0;
	int                  checked = 0;

	drr_tracker #(.BANKS(BANKS)) u_dut (.*);
	drr_ctl_model #(.BW(BW)) u_ctl (.*);

	// 250 MHz command clock
	always #2 clk = ~clk;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Hang guard
	initial begin
		repeat (5000) @(posedge clk);
		err_total++;
		summarize();
	end

	// Main sequence
	initial begin
		logic [1:0] res;
		logic [8:0] ro;
		rst_b = 1'h0;
		por_b = 1'h0;
		repeat (12) @(negedge clk);
		rst_b = 1'h1;
		por_b = 1'h1;
		u_ctl.rd(2'h2, 2'h0, ro);
		chk(ro, 9'h1C0);
		u_ctl.rd(2'h3, 2'h3, ro);
		chk(ro, 9'h108);
		u_ctl.rd(2'h1, 2'h2, ro);
		chk(ro, 9'h100);
		$display("readout test done");
		u_ctl.rep(1, 18'h00011, res);
		chk(res, 2'h1);
		u_ctl.mode(1'h1, 1'h0);
		chk({soft_mode, hard_mode}, 2'h2);
		u_ctl.rep(2, 18'h00123, res);
		chk({res, bank_state[5:4]}, 4'h9);
		u_ctl.lk(2, 18'h00123, res);
		chk(res, 2'h3);
		u_ctl.rep(3, 18'h00055, res);
		chk({res, bank_state[7:4]}, 6'h25);
		u_ctl.rep(2, 18'h00200, res);
		chk(res, 2'h2);
		u_ctl.lk(2, 18'h00123, res);
		chk(res, 2'h2);
		u_ctl.lk(2, 18'h00200, res);
		chk(res, 2'h3);
		$display("soft repair test done");
		u_ctl.mode(1'h0, 1'h1);
		chk({soft_mode, hard_mode}, 2'h1);
		u_ctl.rep(2, 18'h3FFFF, res);
		chk({res, bank_state[7:4]}, 6'h27);
		u_ctl.lk(2, 18'h3FFFF, res);
		chk(res, 2'h3);
		u_ctl.rep(15, 18'h00007, res);
		chk({res, bank_state[31:30]}, 4'hB);
		u_ctl.rep(2, 18'h00005, res);
		chk(res, 2'h1);
		u_ctl.mode(1'h1, 1'h0);
		u_ctl.rep(2, 18'h00009, res);
		chk(res, 2'h1);
		u_ctl.lk(2, 18'h3FFFF, res);
		chk(res, 2'h3);
		u_ctl.mode(1'h1, 1'h1);
		u_ctl.rep(4, 18'h00004, res);
		chk(res, 2'h1);
		$display("hard repair test done");
		@(negedge clk);
		rst_b = 1'h0;
		repeat (2) @(negedge clk);
		rst_b = 1'h1;
		@(negedge clk);
		chk({soft_mode, hard_mode, bank_state[7:4]}, 6'h03);
		u_ctl.rd(2'h2, 2'h0, ro);
		chk(ro, 9'h1C0);
		$display("reset test done");
		summarize();
	end
endmodule
